// *** core/eebap_map.svh ***
// Purpose: offsets, field positions and counts of the storage access port
// Assumes: six-bit I/O register address, 100 MHz I_REF_CLK
// Notes:   definitions only
`ifndef EEBAP_MAP_SVH
`define EEBAP_MAP_SVH

// ----------------------------------------------------------------------
// register offsets in I/O space
// ----------------------------------------------------------------------
`define EEBAP_OFS_CTRL       6'h1c
`define EEBAP_OFS_DATA       6'h1d
`define EEBAP_OFS_ADDR_LOW   6'h1e
`define EEBAP_OFS_ADDR_HIGH  6'h1f

// ----------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------
`define EEBAP_BIT_READ_STROBE   0
`define EEBAP_BIT_WRITE_STROBE  1
`define EEBAP_BIT_MASTER_WE     2
`define EEBAP_BIT_READY_IE      3

// ----------------------------------------------------------------------
// sizes, reset values and counts
// ----------------------------------------------------------------------
`define EEBAP_DEPTH            512
`define EEBAP_ADDR_W           9
`define EEBAP_CTRL_RESET       8'h00
`define EEBAP_MWE_CYCLES       3'h4
`define EEBAP_READ_STALL       3'h4
`define EEBAP_WRITE_STALL      3'h2
`define EEBAP_WRITE_OSC_CYCLES 8448

`endif

// *** core/eebap_pkg.sv ***
// Purpose: shared types of the storage access port
// Assumes: eebap_map.svh holds the numbers
// Notes:   none
`default_nettype none
`include "eebap_map.svh"
package eebap_pkg;
  typedef logic [`EEBAP_ADDR_W-1:0] eebap_addr_t;
  typedef logic [7:0]               eebap_byte_t;
  typedef logic [5:0]               eebap_io_addr_t;
  typedef enum logic [1:0] {
    EEBAP_IDLE  = 2'b00,
    EEBAP_READ  = 2'b01,
    EEBAP_WRITE = 2'b10
  } eebap_state_t;
endpackage
`default_nettype wire

// *** core/eebap_store.sv ***
// Purpose: 512-byte non-volatile array, byte wide
// Assumes: write enable lasts one cycle
// Notes:   contents hold across reset
`default_nettype none
module eebap_store (
  input  wire logic   clk,  // reference clock
  eebap_store_if.mem  port  // array port
);
  import eebap_pkg::*;

  eebap_byte_t mem_q [`EEBAP_DEPTH];
  eebap_byte_t rdata_q;

  // byte write and registered read, every byte on its own
  always_ff @(posedge clk) begin
    if (port.we) begin
      mem_q[port.addr] <= port.wdata;
    end
    rdata_q <= mem_q[port.addr];
  end

  assign port.rdata = rdata_q;
endmodule
`default_nettype wire

// *** core/eebap_store_if.sv ***
// Purpose: link between the access controller and the byte array
// Assumes: one clock
// Notes:   read data is registered in the array
`default_nettype none
interface eebap_store_if;
  import eebap_pkg::*;
  eebap_addr_t addr;
  eebap_byte_t wdata;
  logic        we;
  eebap_byte_t rdata;
  modport ctrl (output addr, output wdata, output we, input rdata);
  modport mem  (input addr, input wdata, input we, output rdata);
endinterface
`default_nettype wire

// *** core/eebap_top.sv ***
// Purpose: byte access port between the CPU I/O space and data storage
// Assumes: CPU I/O strobes on I_REF_CLK; I_CAL_OSC is the free 1 MHz oscillator
// Notes:   write duration is counted on oscillator edges
//
// Function
// [R1] 512 bytes of storage, each byte read and written on its own.
// [R2] address, data and control registers sit in I/O register space.
// [R3] writes time themselves; the write strobe shows when next byte may go.
// [R4] a read trigger stalls the CPU four clock cycles.
// [R5] a write trigger stalls the CPU two clock cycles.
// [R6] nine-bit address: bit 8 in high byte, bits 7..0 in low byte.
// [R7] addresses 0 to 511 each pick one distinct byte.
// [R8] upper seven address bits are read-only and read zero.
// [R9] address bits are not reset; their value after reset is undefined.
// [R10] software loads a valid address before any read or write.
// [R11] a write stores the data register into the addressed byte.
// [R12] a read loads the addressed byte into the data register.
// [R13] only the guarded write sequence changes storage.
// [R14] master enable clears after four cycles; strobe without it does nothing.
// [R15] strobe stays set during a write; ready interrupt while clear and enabled.
// [R16] reads act at once; reads and address changes blocked while writing.
// [R17] a write lasts 8448 cycles of the calibrated 1 MHz oscillator.
// [R18] data register is plain read-write storage keeping its last value.
`default_nettype none
`include "eebap_map.svh"
module eebap_top #(
  parameter int unsigned WRITE_OSC_CYCLES = `EEBAP_WRITE_OSC_CYCLES  // write length
) (
  input  wire logic                   I_REF_CLK,    // 100 MHz clock
  input  wire logic                   I_RSTN,       // async reset, active low
  input  wire logic                   I_CAL_OSC,    // calibrated 1 MHz oscillator pin
  input  wire eebap_pkg::eebap_io_addr_t I_IO_ADDR, // I/O register address
  input  wire logic                   I_IO_WE,      // I/O write strobe
  input  wire logic                   I_IO_RE,      // I/O read strobe
  input  wire eebap_pkg::eebap_byte_t I_IO_WDATA,   // I/O write data
  output logic [7:0]                  O_IO_RDATA,   // I/O read data, one cycle late
  output logic                        O_CPU_STALL,  // halts the CPU
  output logic                        O_READY_IRQ   // storage ready interrupt
);
  import eebap_pkg::*;

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  eebap_store_if store ();

  eebap_state_t state_q, state_d;
  logic [2:0]   mwe_cnt_q, mwe_cnt_d;
  logic         mwe_q, mwe_d;
  logic         ready_ie_q, ready_ie_d;
  logic [2:0]   stall_cnt_q, stall_cnt_d;
  logic [13:0]  osc_cnt_q, osc_cnt_d;
  logic         osc_s1_q, osc_s2_q, osc_s3_q;
  logic         osc_tick;
  eebap_addr_t  addr_q, addr_d;
  eebap_byte_t  data_q, data_d;
  eebap_byte_t  wbuf_q, wbuf_d;
  logic         mem_we_q, mem_we_d;
  eebap_byte_t  rdata_q, rdata_d;
  logic         irq_q, irq_d;
  logic         wr_ctrl, start_rd, start_wr, busy;

  localparam logic [13:0] OSC_LAST = 14'(WRITE_OSC_CYCLES - 1);

  eebap_store u_store (
    .clk  (I_REF_CLK),
    .port (store.mem)
  );

  // ----------------------------------------------------------------------
  // oscillator synchroniser and edge detect
  // ----------------------------------------------------------------------
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
      osc_s3_q <= 1'b0;
    end else begin
      osc_s1_q <= I_CAL_OSC;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
    end
  end

  assign osc_tick = osc_s2_q & ~osc_s3_q;  // one rising edge of the oscillator

  // ----------------------------------------------------------------------
  // request decode
  // ----------------------------------------------------------------------
  assign busy     = (state_q == EEBAP_WRITE) || mem_we_q;  // write in progress or array write still landing
  assign wr_ctrl  = I_IO_WE && (I_IO_ADDR == `EEBAP_OFS_CTRL);  // [R2]
  assign start_rd = wr_ctrl && I_IO_WDATA[`EEBAP_BIT_READ_STROBE] && !busy;  // [R16]
  assign start_wr = wr_ctrl && I_IO_WDATA[`EEBAP_BIT_WRITE_STROBE] && mwe_q
                    && !busy;  // [R13] [R14]

  // ----------------------------------------------------------------------
  // control next state
  // ----------------------------------------------------------------------
  always_comb begin
    state_d     = state_q;
    mwe_d       = mwe_q;
    mwe_cnt_d   = mwe_cnt_q;
    ready_ie_d  = ready_ie_q;
    stall_cnt_d = (stall_cnt_q != 3'h0) ? stall_cnt_q - 3'h1 : 3'h0;
    osc_cnt_d   = osc_cnt_q;
    mem_we_d    = 1'b0;
    // master enable times out four cycles after being set
    if (mwe_q) begin
      if (mwe_cnt_q == `EEBAP_MWE_CYCLES - 3'h1) begin
        mwe_d = 1'b0;  // [R14]
      end else begin
        mwe_cnt_d = mwe_cnt_q + 3'h1;
      end
    end
    if (wr_ctrl) begin
      ready_ie_d = I_IO_WDATA[`EEBAP_BIT_READY_IE];
      if (I_IO_WDATA[`EEBAP_BIT_MASTER_WE] && !mwe_q) begin
        mwe_d     = 1'b1;
        mwe_cnt_d = 3'h0;
      end
    end
    case (state_q)
      EEBAP_IDLE: begin
        if (start_wr) begin
          state_d     = EEBAP_WRITE;  // [R3] [R15]
          mwe_d       = 1'b0;
          osc_cnt_d   = 14'h0000;
          stall_cnt_d = `EEBAP_WRITE_STALL;  // [R5]
        end else if (start_rd) begin
          state_d     = EEBAP_READ;
          stall_cnt_d = `EEBAP_READ_STALL;  // [R4]
        end
      end
      EEBAP_READ: begin
        state_d = EEBAP_IDLE;  // array data lands in the data register now
      end
      EEBAP_WRITE: begin
        if (osc_tick) begin
          if (osc_cnt_q == OSC_LAST) begin
            state_d  = EEBAP_IDLE;  // [R17] [R3]
            mem_we_d = 1'b1;  // [R11]
          end else begin
            osc_cnt_d = osc_cnt_q + 14'h0001;
          end
        end
      end
      default: begin
        state_d = EEBAP_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // data path next values and read-back
  // ----------------------------------------------------------------------
  always_comb begin
    addr_d  = addr_q;
    data_d  = data_q;
    wbuf_d  = wbuf_q;
    rdata_d = rdata_q;
    if (I_IO_WE && !busy && I_IO_ADDR == `EEBAP_OFS_ADDR_HIGH) begin
      addr_d[8] = I_IO_WDATA[0];  // [R6] [R16]
    end
    if (I_IO_WE && !busy && I_IO_ADDR == `EEBAP_OFS_ADDR_LOW) begin
      addr_d[7:0] = I_IO_WDATA;  // [R6] [R7]
    end
    if (I_IO_WE && I_IO_ADDR == `EEBAP_OFS_DATA) begin
      data_d = I_IO_WDATA;  // [R18]
    end
    if (state_q == EEBAP_READ) begin
      data_d = store.rdata;  // [R12]
    end
    if (start_wr) begin
      wbuf_d = data_q;  // [R11]
    end
    if (I_IO_RE) begin
      case (I_IO_ADDR)
        `EEBAP_OFS_ADDR_HIGH: rdata_d = {7'h00, addr_q[8]};  // [R8]
        `EEBAP_OFS_ADDR_LOW:  rdata_d = addr_q[7:0];
        `EEBAP_OFS_DATA:      rdata_d = data_q;
        `EEBAP_OFS_CTRL:      rdata_d = {4'h0, ready_ie_q, mwe_q, busy, 1'b0};  // [R3]
        default:              rdata_d = 8'h00;
      endcase
    end
    irq_d = ready_ie_q && !busy;  // [R15]
  end

  // ----------------------------------------------------------------------
  // control and output registers
  // ----------------------------------------------------------------------
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      state_q     <= EEBAP_IDLE;
      mwe_q       <= 1'b0;
      mwe_cnt_q   <= 3'h0;
      ready_ie_q  <= 1'b0;
      stall_cnt_q <= 3'h0;
      osc_cnt_q   <= 14'h0000;
      mem_we_q    <= 1'b0;
      rdata_q     <= `EEBAP_CTRL_RESET;
      irq_q       <= 1'b0;
      O_CPU_STALL <= 1'b0;
    end else begin
      state_q     <= state_d;
      mwe_q       <= mwe_d;
      mwe_cnt_q   <= mwe_cnt_d;
      ready_ie_q  <= ready_ie_d;
      stall_cnt_q <= stall_cnt_d;
      osc_cnt_q   <= osc_cnt_d;
      mem_we_q    <= mem_we_d;
      rdata_q     <= rdata_d;
      irq_q       <= irq_d;
      O_CPU_STALL <= (stall_cnt_d != 3'h0);  // [R4] [R5]
    end
  end

  // address and data hold no reset value
  always_ff @(posedge I_REF_CLK) begin
    addr_q <= addr_d;  // [R9]
    data_q <= data_d;
    wbuf_q <= wbuf_d;
  end

  // ----------------------------------------------------------------------
  // array connection and outputs
  // ----------------------------------------------------------------------
  assign store.addr  = addr_q;  // [R1] [R7]
  assign store.wdata = wbuf_q;
  assign store.we    = mem_we_q;
  assign O_IO_RDATA  = rdata_q;
  assign O_READY_IRQ = irq_q;
endmodule
`default_nettype wire

// *** verification/eebap_asserts.sv ***
// Purpose: port-level checker of the storage access port
// Assumes: control at 0x1c, data 0x1d, address low 0x1e, high 0x1f
// Notes:   helper counts cycles since the last master enable write
`default_nettype none
module eebap_asserts #(
  parameter int unsigned WRITE_OSC_CYCLES = 8448  // write length
) (
  input wire logic                      I_REF_CLK,    // clock
  input wire logic                      I_RSTN,       // reset, active low
  input wire logic                      I_CAL_OSC,    // oscillator
  input wire eebap_pkg::eebap_io_addr_t I_IO_ADDR,    // register address
  input wire logic                      I_IO_WE,      // write strobe
  input wire logic                      I_IO_RE,      // read strobe
  input wire eebap_pkg::eebap_byte_t    I_IO_WDATA,   // write data
  input wire logic [7:0]                O_IO_RDATA,   // read data
  input wire logic                      O_CPU_STALL,  // cpu halt
  input wire logic                      O_READY_IRQ   // ready interrupt
);
  import eebap_pkg::*;
  logic       ctl_wr;
  logic       idle;
  logic [2:0] age_q;
  logic [2:0] age_d;
  // age of the master enable, saturating at 7
  always_comb begin
    ctl_wr = I_IO_WE && I_IO_ADDR == 6'h1c;
    idle   = O_READY_IRQ && !O_CPU_STALL;
    age_d  = (ctl_wr && I_IO_WDATA[2]) ? 3'h0 : (age_q == 3'h7) ? age_q : age_q + 3'h1;
  end
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      age_q <= 3'h7;
    end else begin
      age_q <= age_d;
    end
  end
  default clocking dclk @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RSTN);
  a_read_stall: assert property (ctl_wr && I_IO_WDATA[1:0] == 2'b01 && idle
    |=> O_CPU_STALL [*4] ##1 !O_CPU_STALL) else $error("read stall length wrong");
  a_write_stall: assert property (ctl_wr && I_IO_WDATA[1] && age_q <= 3'h3 && idle
    |=> O_CPU_STALL [*2] ##1 !O_CPU_STALL) else $error("write stall length wrong");
  a_irq_drops: assert property (ctl_wr && I_IO_WDATA[3:1] == 3'b101 && age_q <= 3'h3 && idle
    |-> ##2 !O_READY_IRQ) else $error("ready irq kept during write");
  a_stale_strobe: assert property (ctl_wr && I_IO_WDATA[3:0] == 4'ha && age_q > 3'h3 && idle
    |=> (!O_CPU_STALL && O_READY_IRQ) [*2]) else $error("strobe acted without enable");
  a_unmapped_zero: assert property (I_IO_RE && I_IO_ADDR < 6'h1c
    |=> O_IO_RDATA == 8'h00) else $error("unmapped read not zero");
  a_high_zero: assert property (I_IO_RE && I_IO_ADDR == 6'h1f
    |=> O_IO_RDATA[7:1] == 7'h00) else $error("upper address bits not zero");
  a_ctrl_resv: assert property (I_IO_RE && I_IO_ADDR == 6'h1c
    |=> O_IO_RDATA[7:4] == 4'h0 && !O_IO_RDATA[0]) else $error("control reserved bits set");
  a_rdata_hold: assert property (!I_IO_RE |=> $stable(O_IO_RDATA))
    else $error("read data moved without read");
  a_stall_bound: assert property ($rose(O_CPU_STALL) |-> ##[1:4] !O_CPU_STALL)
    else $error("stall too long");
endmodule
bind eebap_top eebap_asserts #(.WRITE_OSC_CYCLES(WRITE_OSC_CYCLES)) eebap_asserts_i (
  .I_REF_CLK(I_REF_CLK), .I_RSTN(I_RSTN), .I_CAL_OSC(I_CAL_OSC), .I_IO_ADDR(I_IO_ADDR),
  .I_IO_WE(I_IO_WE), .I_IO_RE(I_IO_RE), .I_IO_WDATA(I_IO_WDATA), .O_IO_RDATA(O_IO_RDATA),
  .O_CPU_STALL(O_CPU_STALL), .O_READY_IRQ(O_READY_IRQ));
`default_nettype wire

// *** verification/eebap_osc_model.sv ***
// Purpose: far-side model of the calibrated 1 MHz write oscillator
// Assumes: oscillator runs free, as on the device
// Notes:   phase unrelated to the bench clock
`default_nettype none
module eebap_osc_model #(
  parameter int unsigned HALF_NS = 500  // half period in ns
) (
  output var logic o_osc  // oscillator pin
);
  timeunit 1ns;
  timeprecision 100ps;
  // free-running square wave, offset from the clock edges
  initial begin
    o_osc = 1'b0;
    #3.3;
    forever #HALF_NS o_osc = ~o_osc;
  end
endmodule
`default_nettype wire

// *** verification/testbench.sv ***
// Purpose: self-checking bench of the storage access port
// Assumes: write length shortened to 4 oscillator cycles
// Notes:   expected bytes kept in a bench-side shadow array
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import eebap_pkg::*;
  logic           clk = 1'b0, rst_n = 1'b0, we = 1'b0, re = 1'b0, osc, stall, irq;
  eebap_io_addr_t ioa = 6'h00;
  eebap_byte_t    wd = 8'h00, v;
  logic [7:0]     rd;
  logic [15:0]    lfsr = 16'he52d;
  int             fails = 0, checks = 0, cyc = 0, t0;
  eebap_byte_t    shadow [int];
  eebap_addr_t    a;
  eebap_top #(.WRITE_OSC_CYCLES(4)) eebap_top_i (.I_REF_CLK(clk), .I_RSTN(rst_n),
    .I_CAL_OSC(osc), .I_IO_ADDR(ioa), .I_IO_WE(we), .I_IO_RE(re), .I_IO_WDATA(wd),
    .O_IO_RDATA(rd), .O_CPU_STALL(stall), .O_READY_IRQ(irq));
  eebap_osc_model eebap_osc_model_i (.o_osc(osc));
  // random source and expected high address byte
  function automatic logic [15:0] step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic eebap_byte_t high_of(input eebap_addr_t ad);
    return {7'h00, ad[8]};
  endfunction
  task automatic check(input eebap_byte_t seen, input eebap_byte_t exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // next free edge: stall is looked at settled, the request goes out on the edge
  task automatic slot();
    @(negedge clk);
    while (stall === 1'b1) begin
      @(negedge clk);
    end
    @(posedge clk);
  endtask
  task automatic wr(input eebap_io_addr_t ad, input eebap_byte_t d);
    slot();
    ioa <= ad;
    wd <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask
  task automatic rdr(input eebap_io_addr_t ad);
    slot();
    ioa <= ad;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    @(negedge clk);
    v = rd;
  endtask
  task automatic put_addr(input eebap_addr_t ad);
    wr(6'h1f, high_of(ad));
    wr(6'h1e, ad[7:0]);
  endtask
  always #5 clk = ~clk;
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fails++;
      give_verdict();
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    wr(6'h1c, 8'h08);
    wr(6'h1f, 8'hff);
    rdr(6'h1f);
    check(v, 8'h01);
    put_addr(9'h1a5);
    rdr(6'h1e);
    check(v, 8'ha5);
    wr(6'h1d, 8'h5a);
    rdr(6'h1d);
    check(v, 8'h5a);
    wr(6'h05, 8'hff);
    rdr(6'h05);
    check(v, 8'h00);
    $display("test registers done");
    for (int i = 0; i < 6; i++) begin
      lfsr = step(lfsr);
      a = (i == 0) ? 9'h000 : (i == 1) ? 9'h1ff : lfsr[8:0];
      shadow[a] = lfsr[15:8];
      put_addr(a);
      wr(6'h1d, lfsr[15:8]);
      wr(6'h1c, 8'h0c);
      wr(6'h1c, 8'h0a);
      t0 = cyc;
      @(negedge clk);
      check({7'h00, stall}, 8'h01);
      rdr(6'h1c);
      check(v, 8'h0a);
      check({7'h00, irq}, 8'h00);
      wr(6'h1e, ~a[7:0]);
      wr(6'h1c, 8'h09);
      while (v[1] === 1'b1 && cyc - t0 < 2000) rdr(6'h1c);
      check({7'h00, cyc - t0 >= 300 && cyc - t0 <= 420}, 8'h01);
      check({7'h00, irq}, 8'h01);
      rdr(6'h1e);
      check(v, a[7:0]);
      rdr(6'h1d);
      check(v, shadow[a]);
    end
    $display("test writes done");
    foreach (shadow[k]) begin
      put_addr(k[8:0]);
      wr(6'h1c, 8'h09);
      @(negedge clk);
      check({7'h00, stall}, 8'h01);
      rdr(6'h1d);
      check(v, shadow[k]);
    end
    $display("test readback done");
    put_addr(9'h000);
    wr(6'h1d, ~shadow[0]);
    wr(6'h1c, 8'h0a);
    wr(6'h1c, 8'h0c);
    repeat (5) @(posedge clk);
    wr(6'h1c, 8'h0a);
    rdr(6'h1c);
    check(v, 8'h08);
    wr(6'h1c, 8'h09);
    rdr(6'h1d);
    check(v, shadow[0]);
    $display("test guard done");
    @(posedge clk);
    rst_n <= 1'b0;
    @(negedge clk);
    check({6'h00, stall, irq}, 8'h00);
    @(posedge clk);
    rst_n <= 1'b1;
    put_addr(9'h000);
    wr(6'h1c, 8'h01);
    rdr(6'h1d);
    check(v, shadow[0]);
    rdr(6'h1c);
    check(v, 8'h00);
    $display("test reset done");
    give_verdict();
  end
endmodule
`default_nettype wire
